// File: rtl/osc_divider_defines.vh
// Constants for the on-chip oscillator and its divider.
`ifndef OSC_DIVIDER_DEFINES_VH
`define OSC_DIVIDER_DEFINES_VH
`define OSC_CLK_MHZ 200
`define OSC_NOMINAL_KHZ 8000
`define OSC_MIN_KHZ 4000
`define OSC_MAX_KHZ 10000
`define OSC_PHASE_CYCLES ((`OSC_CLK_MHZ * 1000) / (2 * `OSC_NOMINAL_KHZ))
`define OSC_PHASE_WIDTH 8
// Last phase count, OSC_PHASE_CYCLES - 1, held at the phase counter's width.
`define OSC_PHASE_LAST 8'h0b
`define DIV_WIDTH 20
`define TAP0_BIT 4
`define TAP1_BIT 9
`define TAP2_BIT 14
`define TAP3_BIT 19
`define TIMEOUT_BIT 12
`define TAP_SEL_RESET 2'h0
`define DIV_RESET 20'h0_0000
`endif

// File: rtl/tap_resync.v
// Resynchronising register for one selected divider tap.
`timescale 1ns/10ps
module tap_resync (
	input wire clk,
	input wire rst,
	input wire osc_edge,
	input wire [3:0] taps,
	input wire [1:0] sel,
	output reg tap_out
);
	always @(posedge clk) begin
		if (rst) begin
			tap_out <= 1'b0;
		end else if (osc_edge) begin
			tap_out <= taps[sel]; // [R4] [R7]
		end
	end
endmodule // tap_resync

// File: rtl/internal_oscillator_divider.v
// Internal oscillator model with binary divider and resynchronised taps.
`timescale 1ns/10ps
`include "osc_divider_defines.vh"

// What this block does
// R1: Oscillator clocks power-on time-out, memory clearing, and master config clock.
// R2: Oscillator runs nominally at 8 MHz; real range is 4 to 10 MHz.
// R3: Divider exposes taps at bits four, nine, fourteen and nineteen.
// R4: User picks any two taps; each is resynchronised before output.
// R5: After configuration the raw oscillator may reach user logic.
// R6: Oscillator stops after configuration unless the primitive is used.
// R7: Selected taps are registered on oscillator edges, so stay glitch-free.
module internal_oscillator_divider (
	input wire CLK,
	input wire RST,
	input wire CONFIG_DONE,
	input wire MASTER_MODE,
	input wire PRIMITIVE_USED,
	input wire OSC_OUT_EN,
	input wire [1:0] TAP_SEL_A,
	input wire [1:0] TAP_SEL_B,
	output reg OSC_RUNNING,
	output reg CONFIG_CLOCK_OUT,
	output reg TIMEOUT_DONE,
	output reg CLEAR_TICK,
	output reg USER_OSC,
	output reg USER_TAP_A,
	output reg USER_TAP_B
);
	// ----------------------------------------------------------------
	// Oscillator
	// ----------------------------------------------------------------
	// The oscillator is modelled as a divided system clock. Its period is
	// only nominal; nothing downstream relies on the exact value. [R2]
	reg [`OSC_PHASE_WIDTH-1:0] phase;
	reg osc;
	reg run;
	wire osc_edge;
	wire [`OSC_PHASE_WIDTH-1:0] phase_last;

	assign phase_last = `OSC_PHASE_LAST;
	assign osc_edge = run && (phase == phase_last) && !osc;

	always @(posedge CLK) begin
		if (RST) begin
			phase <= {`OSC_PHASE_WIDTH{1'b0}};
			osc <= 1'b0;
		end else if (run) begin
			if (phase == phase_last) begin
				phase <= {`OSC_PHASE_WIDTH{1'b0}};
				osc <= !osc; // [R2]
			end else begin
				phase <= phase + 1'b1;
			end
		end
	end

	// Once stopped after configuration the oscillator stays off until the
	// next reset, which saves power in designs that never use it.
	always @(posedge CLK) begin
		if (RST) begin
			run <= 1'b1;
		end else if (CONFIG_DONE && !PRIMITIVE_USED) begin
			run <= 1'b0; // [R6]
		end
	end

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	reg [`DIV_WIDTH-1:0] div;
	wire [3:0] taps;

	always @(posedge CLK) begin
		if (RST) begin
			div <= `DIV_RESET;
		end else if (osc_edge) begin
			div <= div + 1'b1;
		end
	end

	assign taps = {div[`TAP3_BIT], div[`TAP2_BIT], div[`TAP1_BIT],
		div[`TAP0_BIT]}; // [R3]

	// ----------------------------------------------------------------
	// Configuration services
	// ----------------------------------------------------------------
	always @(posedge CLK) begin
		if (RST) begin
			TIMEOUT_DONE <= 1'b0;
			CLEAR_TICK <= 1'b0;
			CONFIG_CLOCK_OUT <= 1'b0;
		end else begin
			if (osc_edge && div[`TIMEOUT_BIT]) begin
				TIMEOUT_DONE <= 1'b1; // [R1]
			end
			CLEAR_TICK <= osc_edge && !CONFIG_DONE; // [R1]
			CONFIG_CLOCK_OUT <= MASTER_MODE && !CONFIG_DONE && osc; // [R1]
		end
	end

	// ----------------------------------------------------------------
	// User outputs
	// ----------------------------------------------------------------
	wire tap_a;
	wire tap_b;
	wire user_ok;

	assign user_ok = CONFIG_DONE && PRIMITIVE_USED;

	tap_resync u_tap_a (
		.clk(CLK),
		.rst(RST),
		.osc_edge(osc_edge),
		.taps(taps),
		.sel(TAP_SEL_A),
		.tap_out(tap_a)
	);

	tap_resync u_tap_b (
		.clk(CLK),
		.rst(RST),
		.osc_edge(osc_edge),
		.taps(taps),
		.sel(TAP_SEL_B),
		.tap_out(tap_b)
	);

	always @(posedge CLK) begin
		if (RST) begin
			USER_OSC <= 1'b0;
			USER_TAP_A <= 1'b0;
			USER_TAP_B <= 1'b0;
			OSC_RUNNING <= 1'b0;
		end else begin
			USER_OSC <= user_ok && OSC_OUT_EN && osc; // [R5]
			USER_TAP_A <= user_ok && tap_a; // [R4]
			USER_TAP_B <= user_ok && tap_b; // [R4]
			OSC_RUNNING <= run;
		end
	end
endmodule // internal_oscillator_divider

// File: verification/osc_chk_asserts.sv
// Port-level assertions for the oscillator divider.
`timescale 1ns/10ps
module osc_chk (input wire CLK, RST, CONFIG_DONE, MASTER_MODE,
	PRIMITIVE_USED, OSC_OUT_EN, OSC_RUNNING, CONFIG_CLOCK_OUT,
	TIMEOUT_DONE, CLEAR_TICK, USER_OSC, USER_TAP_A, USER_TAP_B);
default clocking @(posedge CLK); endclocking
default disable iff (RST);
a_cfg_clk_gate: assert property (!(MASTER_MODE && !CONFIG_DONE) |=>
	!CONFIG_CLOCK_OUT) else $error("config clock out of mode");
a_tick_one_cycle: assert property (CLEAR_TICK |=> !CLEAR_TICK)
	else $error("clear tick too long");
a_tick_period: assert property (CLEAR_TICK |-> ##24
	(CLEAR_TICK || CONFIG_DONE)) else $error("oscillator period off");
a_timeout_sticky: assert property (TIMEOUT_DONE |=> TIMEOUT_DONE)
	else $error("timeout flag dropped");
a_tap_gate: assert property (!(CONFIG_DONE && PRIMITIVE_USED) |=>
	!USER_TAP_A && !USER_TAP_B) else $error("tap before config");
a_user_osc_gate: assert property (!(CONFIG_DONE && PRIMITIVE_USED &&
	OSC_OUT_EN) |=> !USER_OSC) else $error("user osc leaked");
a_osc_stop: assert property (CONFIG_DONE && !PRIMITIVE_USED |->
	##3 !OSC_RUNNING) else $error("oscillator not stopped");
endmodule // osc_chk
bind internal_oscillator_divider osc_chk osc_chk_inst (.*);

// File: verification/internal_oscillator_divider_bench.sv
// Self-checking bench for the oscillator divider.
`timescale 1ns/10ps
`include "osc_divider_defines.vh"
module internal_oscillator_divider_bench;
reg CLK=0, RST=1, CONFIG_DONE=0, MASTER_MODE=1, PRIMITIVE_USED=1;
reg OSC_OUT_EN=1;
reg [1:0] TAP_SEL_A=2'h0, TAP_SEL_B=2'h1;
wire OSC_RUNNING, CONFIG_CLOCK_OUT, TIMEOUT_DONE, CLEAR_TICK;
wire USER_OSC, USER_TAP_A, USER_TAP_B;
int num_errors=0, samples_checked=0;
internal_oscillator_divider internal_oscillator_divider_inst (.*);
initial forever #2.5 CLK = ~CLK;
task check(input string nm, input [31:0] seen, exp);
	samples_checked++;
	if (seen !== exp) begin
		num_errors++;
		$display("MISMATCH %s exp %0d seen %0d", nm, exp, seen);
	end
endtask
task wrap_up;
	$display("errors %0d checks %0d", num_errors, samples_checked);
	if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish;
endtask
task do_reset(input pu);
	@(negedge CLK) RST = 1;
	PRIMITIVE_USED = pu;
	CONFIG_DONE = 0;
	repeat (12) @(negedge CLK);
	RST = 0;
endtask
task pre_config;
	int t, h;
	t = 0;
	h = 0;
	repeat (240) begin
		@(negedge CLK);
		t += CLEAR_TICK;
		h += CONFIG_CLOCK_OUT;
	end
	check("ticks", t, 10);
	check("timeout_early", TIMEOUT_DONE, 0);
	check("cfg_clk_high", h, 120);
	check("tap_a_pre", USER_TAP_A, 0);
endtask
// The first two segments may be partial, so only the third is judged.
task half(input string nm, input b, input [31:0] exp);
	int n;
	logic v;
	for (int k = 0; k < 3; k++) begin
		n = 0;
		v = b ? USER_TAP_B : USER_TAP_A;
		do begin
			@(negedge CLK);
			n++;
		end while ((b ? USER_TAP_B : USER_TAP_A) === v && n < 30000);
	end
	check(nm, n, exp);
endtask
task user_osc_on;
	int h, t;
	h = 0;
	t = 0;
	repeat (240) begin
		@(negedge CLK);
		h += USER_OSC;
		t += CLEAR_TICK;
	end
	check("user_osc_high", h, 120);
	check("tick_after_done", t, 0);
endtask
task slave_mode;
	int h;
	h = 0;
	repeat (48) begin
		@(negedge CLK);
		h += CONFIG_CLOCK_OUT;
	end
	check("cfg_clk_slave", h, 0);
	check("osc_run_pre", OSC_RUNNING, 1);
	check("timeout_reset", TIMEOUT_DONE, 0);
endtask
initial begin
	do_reset(1);
	pre_config;
	@(negedge CLK) CONFIG_DONE = 1;
	half("tap_a", 0, (2 * `OSC_PHASE_CYCLES) << `TAP0_BIT);
	half("tap_b", 1, (2 * `OSC_PHASE_CYCLES) << `TAP1_BIT);
	user_osc_on;
	@(negedge CLK) OSC_OUT_EN = 0;
	repeat (3) @(negedge CLK);
	check("user_osc_off", USER_OSC, 0);
	check("cfg_clk_done", CONFIG_CLOCK_OUT, 0);
	do_reset(0);
	@(negedge CLK) MASTER_MODE = 0;
	slave_mode;
	@(negedge CLK) CONFIG_DONE = 1;
	repeat (4) @(negedge CLK);
	check("osc_stopped", OSC_RUNNING, 0);
	check("tap_a_stop", USER_TAP_A, 0);
	wrap_up;
end
initial begin
	#400000;
	num_errors++;
	wrap_up;
end
endmodule // internal_oscillator_divider_bench
